//--- bench/smi_sdram_model.sv
// Behavioural SDR SDRAM sitting on the shared memory pins
`timescale 1ns/1ps
module smi_sdram_model
  import smi_pkg::*;
(
  // Memory pins
  input  wire logic        mclk_i,
  input  wire logic [3:0]  dyn_n_i,
  input  wire logic [2:0]  cmd_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [1:0]  bank_i,
  input  wire logic [3:0]  mask_i,
  input  wire logic [31:0] data_i,
  output logic      [31:0] data_o,
  output logic             fb_clk_o
);
  logic [31:0] mem [logic [29:0]];
  logic [12:0] row_r [4];
  logic [29:0] key;
  logic [31:0] junk_r = 32'h5a5a_a5a5;
  logic [31:0] rdat_r;
  logic [31:0] tmp;
  logic        rd_r = 1'b0;

  // Board flight time on the returned clock
  assign #3 fb_clk_o = mclk_i;
  assign key = {dyn_n_i, bank_i, row_r[bank_i], addr_i[11], addr_i[9:0]};
  // Released bus shows a changing pattern, never the last value
  assign data_o = rd_r ? rdat_r : junk_r;

  always @(posedge mclk_i)
  begin
    junk_r <= {junk_r[30:0], ~junk_r[31]} ^ 32'h0000_0101;
    if (dyn_n_i != 4'hf && cmd_i != CMD_NOP)
    begin
      rd_r <= 1'b0;
      if (cmd_i == CMD_ACT)
        row_r[bank_i] <= addr_i;
      if (cmd_i == CMD_RD)
      begin
        rd_r   <= 1'b1;
        rdat_r <= mem.exists(key) ? mem[key] : ~junk_r;
      end
      if (cmd_i == CMD_WR)
      begin
        tmp = mem.exists(key) ? mem[key] : 32'h0000_0000;
        for (int i = 0; i < 4; i++)
          if (!mask_i[i])
            tmp[8*i+:8] = data_i[8*i+:8];
        mem[key] = tmp;
      end
    end
  end
endmodule // smi_sdram_model

//--- bench/tb_top.sv
// Self-checking bench of the SDRAM pin interface
`timescale 1ns/1ps
module tb_top
  import smi_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i, rst_ref_n_i, req_i, wr_i, bus32_i, rbc_map_i, two_banks_i;
  logic power_save_i, self_refresh_req_i, fb_src_loop_i, cmd_delay_i;
  logic ack_o, err_o, self_refresh_o, row_strobe_n_o, column_strobe_n_o;
  logic mem_write_en_n_o, output_en_n_o, mem_data_oe_o;
  logic feedback_clk_in_i, mem_clk_loop_i, got_err, oe_seen;
  logic [31:0] addr_i, wdata_i, rdata_o, mem_data_o, mem_data_i;
  logic [31:0] seed, a, d1, d2, msk, got_rd;
  logic [3:0]  be_i, byte_lane_policy_i, mem_clk_en_o, dyn_select_n_o, be;
  logic [3:0]  static_select_n_o, byte_mask_o, byte_lane_sel_n_o;
  logic [3:0]  act_sel, st_sel, bls_seen, wmask;
  logic [1:0]  row_bits_i, col_bits_i, static_width_i, fb_delay_i, v;
  logic [1:0]  mem_clk_out_o, bank_addr_o, act_bank;
  logic [12:0] row_col_addr_o, act_row;
  logic [2:0]  cmd, cmd_q;
  logic [7:0]  tops [12] = '{8'ha0, 8'hb0, 8'hc0, 8'hd0, 8'h80, 8'h90,
                             8'h98, 8'h9c, 8'h00, 8'h84, 8'h94, 8'he0};
  int mismatches = 0;
  int cmp_count = 0;
  int ref_cnt = 0;
  int k, chg;

  always #20 clk_i = ~clk_i;
  assign cmd = {row_strobe_n_o, column_strobe_n_o, mem_write_en_n_o};
  assign mem_clk_loop_i = mem_clk_out_o[0];

  smi_sdram_if u_dut (.clk_i, .rst_n_i, .rst_ref_n_i, .req_i, .addr_i,
    .wr_i, .wdata_i, .be_i, .ack_o, .err_o, .rdata_o, .bus32_i, .rbc_map_i,
    .row_bits_i, .col_bits_i, .two_banks_i, .static_width_i,
    .byte_lane_policy_i, .power_save_i, .self_refresh_req_i, .fb_src_loop_i,
    .cmd_delay_i, .fb_delay_i, .self_refresh_o, .mem_clk_out_o,
    .mem_clk_en_o, .dyn_select_n_o, .static_select_n_o, .row_strobe_n_o,
    .column_strobe_n_o, .mem_write_en_n_o, .row_col_addr_o, .bank_addr_o,
    .byte_mask_o, .output_en_n_o, .byte_lane_sel_n_o, .mem_data_o,
    .mem_data_oe_o, .mem_data_i, .feedback_clk_in_i, .mem_clk_loop_i);

  smi_sdram_model u_mem (.mclk_i(mem_clk_out_o[0]), .dyn_n_i(dyn_select_n_o),
    .cmd_i(cmd), .addr_i(row_col_addr_o), .bank_i(bank_addr_o),
    .mask_i(byte_mask_o), .data_i(mem_data_o), .data_o(mem_data_i),
    .fb_clk_o(feedback_clk_in_i));

  // Pin monitor: what each access put on the memory bus
  always @(posedge clk_i)
  begin
    cmd_q <= cmd;
    if (cmd == CMD_ACT && dyn_select_n_o != 4'hf)
    begin
      act_sel  <= ~dyn_select_n_o;
      act_bank <= bank_addr_o;
      act_row  <= row_col_addr_o;
    end
    if (cmd == CMD_WR && dyn_select_n_o != 4'hf)
      wmask <= byte_mask_o | {4{!mem_data_oe_o}};
    st_sel <= st_sel | ~static_select_n_o;
    oe_seen <= oe_seen | !output_en_n_o;
    if (static_select_n_o != 4'hf)
      bls_seen <= bls_seen | ~byte_lane_sel_n_o;
    if (cmd == CMD_REF && dyn_select_n_o == 4'h0 && cmd_q != CMD_REF)
      ref_cnt <= ref_cnt + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {bank, row} of a byte address under the current geometry
  function automatic logic [31:0] exp_split(input logic [31:0] x);
    logic [27:0] w;
    int          c, r, nb;
    w  = x[27:0] >> (bus32_i ? 2 : 1);
    c  = 8 + int'(col_bits_i);
    r  = 11 + int'(row_bits_i);
    nb = two_banks_i ? 1 : 2;
    return {17'h0, 2'((rbc_map_i ? w >> c : w >> (c + r)) & ((1 << nb) - 1)),
            13'((rbc_map_i ? w >> (c + nb) : w >> c) & ((1 << r) - 1))};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] p, q,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++)
      if (b[i])
        p[8*i+:8] = q[8*i+:8];
    return p;
  endfunction

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic fail(input string m);
    mismatches++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e)
      fail(m);
  endtask

  task automatic acc(input logic [31:0] x, input logic w,
                     input logic [31:0] d, input logic [3:0] b);
    int i;
    act_sel  = 4'h0;
    st_sel   = 4'h0;
    bls_seen = 4'h0;
    oe_seen  = 1'b0;
    addr_i   = x;
    wr_i     = w;
    wdata_i  = d;
    be_i     = b;
    req_i    = 1'b1;
    for (i = 0; i < 300 && ack_o !== 1'b1; i++)
      @(posedge clk_i) #1;
    if (i == 300)
    begin
      fail("no acknowledge");
      give_verdict;
    end
    got_err = err_o;
    got_rd  = rdata_o;
    req_i   = 1'b0;
    @(posedge clk_i) #1;
  endtask

  task automatic wait_sr(input logic s);
    int i;
    for (i = 0; i < 400 && self_refresh_o !== s; i++)
      @(posedge clk_i) #1;
    if (i == 400)
    begin
      fail("self-refresh state not reached");
      give_verdict;
    end
  endtask

  initial
  begin
    {rst_n_i, rst_ref_n_i, req_i, wr_i, power_save_i, self_refresh_req_i} = '0;
    {addr_i, wdata_i, be_i, byte_lane_policy_i, static_width_i} = '0;
    {bus32_i, rbc_map_i, two_banks_i, row_bits_i, col_bits_i} = 7'h40;
    {fb_src_loop_i, cmd_delay_i, fb_delay_i} = '0;
    seed = 32'h184c;
    repeat (2) @(posedge clk_i);
    #1;
    {rst_n_i, rst_ref_n_i} = 2'b11;
    chk({31'h0, self_refresh_o}, 32'h0, "self-refresh without request");
    for (k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      byte_lane_policy_i = seed[7:4];
      static_width_i = 2'(seed[9:8] % 3);
      a = {tops[k], 24'h0} | (seed & (k < 4 ? 32'h0fff_fffc :
          k < 8 ? 32'h03ff_fffc : 32'h00ff_fffc));
      acc(a, 1'b0, 32'h0, 4'hf);
      chk({31'h0, got_err}, {31'h0, k > 7}, "error flag");
      chk({28'h0, act_sel}, k < 4 ? 1 << k : 0, "dynamic select");
      chk({28'h0, st_sel}, k inside {[4:7]} ? 1 << (k - 4) : 0,
          "static select");
      if (k inside {[4:7]})
        chk({28'h0, bls_seen}, !byte_lane_policy_i[k-4] ? 32'h0 :
            static_width_i == 2'h0 ? 32'h1 : static_width_i == 2'h1 ?
            32'h3 : 32'hf, "byte lane policy");
      chk({31'h0, oe_seen}, {31'h0, k inside {[4:7]}}, "output enable");
    end
    for (k = 0; k < 16; k++)
    begin
      seed = lfsr(seed);
      {cmd_delay_i, fb_delay_i, fb_src_loop_i, two_banks_i, rbc_map_i} =
        seed[5:0];
      bus32_i = seed[6];
      row_bits_i = k == 0 ? 2'h2 : 2'(seed[8:7] % 3);
      col_bits_i = 2'(seed[10:9] % 3);
      a = {4'ha + 4'(seed[29:28]), seed[27:2], 2'b00};
      d1 = lfsr(seed);
      d2 = lfsr(d1);
      be = d2[3:0] == 4'h0 ? 4'h5 : d2[3:0];
      msk = bus32_i ? 32'hffff_ffff : 32'h0000_ffff;
      acc(a, 1'b1, d1, 4'hf);
      chk({17'h0, act_bank, act_row}, exp_split(a), "bank/row");
      acc(a, 1'b1, d2, be);
      chk({28'h0, wmask}, {28'h0, bus32_i ? ~be : {2'b11, ~be[1:0]}},
          "data mask");
      acc(a, 1'b0, 32'h0, 4'hf);
      chk(got_rd & msk, merge(d1, d2, be) & msk, "read data");
    end
    power_save_i = 1'b1;
    // Look just after a refresh so no wake-up is in progress
    k = ref_cnt;
    for (chg = 0; chg < 300 && ref_cnt == k; chg++)
      @(posedge clk_i) #1;
    if (chg == 300)
    begin
      fail("no refresh while idle");
      give_verdict;
    end
    repeat (16) @(posedge clk_i);
    #1;
    chk({28'h0, mem_clk_en_o}, 32'h0, "idle clock enables");
    self_refresh_req_i = 1'b1;
    wait_sr(1'b1);
    repeat (8) @(posedge clk_i);
    #1;
    v = mem_clk_out_o;
    chg = 0;
    repeat (16)
    begin
      @(posedge clk_i) #1;
      chg += int'(mem_clk_out_o !== v);
    end
    chk(chg, 0, "memory clock in self-refresh");
    self_refresh_req_i = 1'b0;
    wait_sr(1'b0);
    power_save_i = 1'b0;
    acc(a, 1'b0, 32'h0, 4'hf);
    chk(got_rd & msk, merge(d1, d2, be) & msk, "data after sleep");
    ref_cnt = 0;
    rst_n_i = 1'b0;
    repeat (250) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk({31'h0, ref_cnt > 0}, 32'h1, "refresh during reset");
    give_verdict;
  end
endmodule // tb_top

//--- rtl/smi_pkg.sv
// Shared constants, types and decode functions of the SDRAM interface
package smi_pkg;

  // Timing
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         REF_PERIOD_NS = 7800;
  localparam logic [7:0] REF_CYC       = 8'(REF_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [1:0] CAS_LAT       = 2'h2;
  localparam logic [1:0] PH_STEP       = 2'h3;
  localparam logic [1:0] PH_CLK_HI     = 2'h3;
  localparam logic [1:0] PH_CLK_HI2    = 2'h0;

  // Address windows, top address bits
  localparam logic [3:0] DYN0_TOP = 4'ha;
  localparam logic [3:0] DYN1_TOP = 4'hb;
  localparam logic [3:0] DYN2_TOP = 4'hc;
  localparam logic [3:0] DYN3_TOP = 4'hd;
  localparam logic [5:0] ST0_TOP  = 6'h20;
  localparam logic [5:0] ST1_TOP  = 6'h24;
  localparam logic [5:0] ST2_TOP  = 6'h26;
  localparam logic [5:0] ST3_TOP  = 6'h27;

  // Geometry
  localparam logic [4:0] COL_MIN   = 5'h08;
  localparam logic [4:0] ROW_MIN   = 5'h0b;
  localparam int         AP_BIT    = 10;
  localparam logic [3:0] LANES_16  = 4'hc;

  // Command codes {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ACT  = 8'h02,
    S_RW   = 8'h04,
    S_WAIT = 8'h08,
    S_PRE  = 8'h10,
    S_REF  = 8'h20,
    S_SREF = 8'h40,
    S_STAT = 8'h80
  } smi_state_type;

  typedef struct packed {
    logic [3:0]  dyn_n;
    logic [3:0]  stat_n;
    logic [2:0]  cmd;
    logic [12:0] addr;
    logic [1:0]  bank;
    logic [3:0]  mask;
    logic [3:0]  cke;
    logic        oe_n;
    logic [3:0]  bls_n;
    logic [31:0] dout;
    logic        doe;
  } smi_pins_type;

  localparam smi_pins_type PINS_IDLE = '{dyn_n: 4'hf, stat_n: 4'hf,
    cmd: CMD_NOP, addr: 13'h0000, bank: 2'h0, mask: 4'hf, cke: 4'hf,
    oe_n: 1'b1, bls_n: 4'hf, dout: 32'h0000_0000, doe: 1'b0};
  localparam smi_pins_type PINS_REF = '{dyn_n: 4'h0, stat_n: 4'hf,
    cmd: CMD_REF, addr: 13'h0000, bank: 2'h0, mask: 4'hf, cke: 4'hf,
    oe_n: 1'b1, bls_n: 4'hf, dout: 32'h0000_0000, doe: 1'b0};

  typedef struct packed {
    logic [1:0]  bank;
    logic [12:0] row;
    logic [12:0] col;
  } smi_split_type;

  function automatic logic [3:0] dyn_dec(input logic [31:0] a);
    logic [3:0] h;
    h = 4'h0;
    if (a[31:28] == DYN0_TOP) h = 4'h1;
    if (a[31:28] == DYN1_TOP) h = 4'h2;
    if (a[31:28] == DYN2_TOP) h = 4'h4;
    if (a[31:28] == DYN3_TOP) h = 4'h8;
    return h;
  endfunction

  function automatic logic [3:0] stat_dec(input logic [31:0] a);
    logic [3:0] h;
    h = 4'h0;
    if (a[31:26] == ST0_TOP) h = 4'h1;
    if (a[31:26] == ST1_TOP) h = 4'h2;
    if (a[31:26] == ST2_TOP) h = 4'h4;
    if (a[31:26] == ST3_TOP) h = 4'h8;
    return h;
  endfunction

  // Bank/row/column from a byte address
  function automatic smi_split_type addr_split(input logic [31:0] a,
    input logic b32, input logic row_bank_col_map, input logic [1:0] rs,
    input logic [1:0] cs, input logic two);
    smi_split_type o;
    logic [27:0]   w;
    logic [4:0]    c;
    logic [4:0]    r;
    logic [4:0]    nb;
    w  = a[27:0] >> (b32 ? 5'd2 : 5'd1);
    c  = COL_MIN + {3'b000, cs};
    r  = ROW_MIN + {3'b000, rs};
    nb = two ? 5'd1 : 5'd2;
    o.col = 13'(w & ((28'h1 << c) - 28'h1));
    if (row_bank_col_map)
    begin
      o.bank = 2'((w >> c) & ((28'h1 << nb) - 28'h1));
      o.row  = 13'((w >> (c + nb)) & ((28'h1 << r) - 28'h1));
    end
    else
    begin
      o.row  = 13'((w >> c) & ((28'h1 << r) - 28'h1));
      o.bank = 2'((w >> (c + r)) & ((28'h1 << nb) - 28'h1));
    end
    return o;
  endfunction

endpackage

//--- rtl/smi_sdram_if.sv
// SDRAM and static memory pin interface with address decode
// Contract
// - Four dynamic selects, each covering a 256 MB window.
// - Windows at A/B/C/D000_0000 assert dynamic selects 0 to 3.
// - 64 MB windows at 8000, 9000, 9800, 9C00 assert static selects 0-3.
// - SDRAM data path is 16 or 32 bits wide.
// - Single data rate only; no DDR, no burst static memory.
// - Bank bits on address lines 13 and 14; row/column on 12:0.
// - With only address line 13 for bank, two banks are reachable.
// - Command is coded by row strobe, column strobe, write and select.
// - Four active-high data masks, one per byte lane.
// - One clock enable per select; power save gates enables when idle, clock in self-refresh.
// - Self-refresh entered and left only by software request.
// - Row addressing of 2k, 4k and 8k rows is supported.
// - Refresh runs in its own reset domain through chip reset.
// - Read feedback from dedicated pin or memory clock loopback.
// - Programmable delays on command outputs and feedback path.
// - Static data width selectable as 8, 16 or 32 bits.
// - Byte lane selects and write enable follow per-select policy.
// - Map bit picks bank-row-column or row-bank-column order.
`timescale 1ns/1ps
module smi_sdram_if
  import smi_pkg::*;
(
  // Clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rst_ref_n_i,
  // Access request
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  be_i,
  output logic             ack_o,
  output logic             err_o,
  output logic      [31:0] rdata_o,
  // Configuration and status
  input  wire logic        bus32_i,
  input  wire logic        rbc_map_i,
  input  wire logic [1:0]  row_bits_i,
  input  wire logic [1:0]  col_bits_i,
  input  wire logic        two_banks_i,
  input  wire logic [1:0]  static_width_i,
  input  wire logic [3:0]  byte_lane_policy_i,
  input  wire logic        power_save_i,
  input  wire logic        self_refresh_req_i,
  input  wire logic        fb_src_loop_i,
  input  wire logic        cmd_delay_i,
  input  wire logic [1:0]  fb_delay_i,
  output logic             self_refresh_o,
  // Memory pins
  output logic      [1:0]  mem_clk_out_o,
  output logic      [3:0]  mem_clk_en_o,
  output logic      [3:0]  dyn_select_n_o,
  output logic      [3:0]  static_select_n_o,
  output logic             row_strobe_n_o,
  output logic             column_strobe_n_o,
  output logic             mem_write_en_n_o,
  output logic      [12:0] row_col_addr_o,
  output logic      [1:0]  bank_addr_o,
  output logic      [3:0]  byte_mask_o,
  output logic             output_en_n_o,
  output logic      [3:0]  byte_lane_sel_n_o,
  output logic      [31:0] mem_data_o,
  output logic             mem_data_oe_o,
  input  wire logic [31:0] mem_data_i,
  input  wire logic        feedback_clk_in_i,
  input  wire logic        mem_clk_loop_i
);

  typedef struct packed {
    smi_state_type st;
    smi_pins_type  p;
    logic [31:0]   addr;
    logic          wr;
    logic [31:0]   wdata;
    logic [3:0]    be;
    logic [1:0]    fbcnt;
    logic          got;
    logic [31:0]   rdata;
    logic          ack;
    logic          err;
    logic          ref_ack;
    logic          stop;
    logic          fb1;
    logic          fb2;
    logic          fb3;
    logic [31:0]   d1;
    logic [31:0]   d2;
  } smi_main_type;

  typedef struct packed {
    logic [1:0] ph;
    logic       clk;
    logic [7:0] cnt;
    logic       pend;
    logic       ovr;
  } smi_ref_type;

  smi_main_type  s_r;
  smi_main_type  s_nxt;
  smi_ref_type   r_r;
  smi_ref_type   r_nxt;
  smi_pins_type  pin_src;
  smi_pins_type  pins_q;
  smi_split_type sp_new;
  smi_split_type sp_cur;
  logic          fb_hit;
  logic          step;
  logic [3:0]    dhit;
  logic [3:0]    shit;
  logic [3:0]    slanes;
  logic          pol;
  logic [31:0]   saddr;

  // Refresh timer, memory clock and reset-time refresh
  always_comb
  begin
    r_nxt     = r_r;
    r_nxt.ph  = r_r.ph + 2'h1;
    r_nxt.clk = !s_r.stop && (r_nxt.ph == PH_CLK_HI ||
                              r_nxt.ph == PH_CLK_HI2);
    r_nxt.cnt = (r_r.cnt == 8'h00) ? REF_CYC - 8'h01 : r_r.cnt - 8'h01;
    if (r_r.ph == PH_STEP)
      r_nxt.ovr = !rst_n_i && r_r.pend;
    r_nxt.pend = (r_r.cnt == 8'h00) || (r_r.pend && !s_r.ref_ack &&
      !(r_r.ph == PH_STEP && !rst_n_i));
    if (!rst_ref_n_i)
    begin
      r_nxt     = '0;
      r_nxt.cnt = REF_CYC - 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    r_r <= r_nxt;
  end

  assign step   = (r_r.ph == PH_STEP);
  assign sp_new = addr_split(addr_i, bus32_i, rbc_map_i, row_bits_i,
                             col_bits_i, two_banks_i);
  assign sp_cur = addr_split(s_r.addr, bus32_i, rbc_map_i, row_bits_i,
                             col_bits_i, two_banks_i);
  assign dhit   = dyn_dec(addr_i);
  assign shit   = stat_dec(addr_i);
  assign slanes = (static_width_i == 2'h0) ? 4'h1 :
                  (static_width_i == 2'h1) ? 4'h3 : 4'hf;
  assign pol    = |(byte_lane_policy_i & shit);
  assign saddr  = addr_i >> static_width_i;

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.ack     = 1'b0;
    s_nxt.err     = 1'b0;
    s_nxt.ref_ack = 1'b0;
    s_nxt.fb1     = fb_src_loop_i ? mem_clk_loop_i
                                  : feedback_clk_in_i;
    s_nxt.fb2     = s_r.fb1;
    s_nxt.fb3     = s_r.fb2;
    s_nxt.d1      = mem_data_i;
    s_nxt.d2      = s_r.d1;
    if (s_r.st == S_WAIT && fb_hit && !s_r.got)
    begin
      s_nxt.fbcnt = s_r.fbcnt + 2'h1;
      if (s_r.fbcnt == CAS_LAT - 2'h1)
      begin
        s_nxt.rdata = s_r.d2;
        s_nxt.got   = 1'b1;
      end
    end
    if (step)
    begin
      unique case (s_r.st)
        S_IDLE:
        begin
          s_nxt.p   = PINS_IDLE;
          s_nxt.p.cke = s_r.p.cke;
          if ((r_r.pend || self_refresh_req_i || req_i) &&
              s_r.p.cke != 4'hf)
            s_nxt.p.cke = 4'hf;
          else if (r_r.pend)
          begin
            s_nxt.st      = S_REF;
            s_nxt.p       = PINS_REF;
            s_nxt.ref_ack = 1'b1;
          end
          else if (self_refresh_req_i)
          begin
            s_nxt.st    = S_SREF;
            s_nxt.p     = PINS_REF;
            s_nxt.p.cke = 4'h0;
          end
          else if (req_i)
          begin
            s_nxt.addr  = addr_i;
            s_nxt.wr    = wr_i;
            s_nxt.wdata = wdata_i;
            s_nxt.be    = be_i;
            if (dhit != 4'h0)
            begin
              s_nxt.st      = S_ACT;
              s_nxt.p.dyn_n = ~dhit;
              s_nxt.p.cmd   = CMD_ACT;
              s_nxt.p.addr  = sp_new.row;
              s_nxt.p.bank  = {sp_new.bank[1] && !two_banks_i,
                               sp_new.bank[0]};
            end
            else if (shit != 4'h0)
            begin
              s_nxt.st       = S_STAT;
              s_nxt.p.stat_n = ~shit;
              {s_nxt.p.bank, s_nxt.p.addr} = saddr[14:0];
              if (wr_i)
              begin
                s_nxt.p.doe   = 1'b1;
                s_nxt.p.dout  = wdata_i;
                s_nxt.p.cmd   = {2'b11, !pol};
                s_nxt.p.bls_n = ~(be_i & slanes);
              end
              else
              begin
                s_nxt.p.oe_n  = 1'b0;
                s_nxt.p.bls_n = pol ? ~slanes : 4'hf;
              end
            end
            else
            begin
              s_nxt.ack = 1'b1;
              s_nxt.err = 1'b1;
            end
          end
          else
            s_nxt.p.cke = power_save_i ? 4'h0 : 4'hf;
        end
        S_REF:
        begin
          s_nxt.st = S_IDLE;
          s_nxt.p  = PINS_IDLE;
        end
        S_SREF:
        begin
          s_nxt.p       = PINS_IDLE;
          s_nxt.p.cke   = 4'h0;
          s_nxt.stop    = power_save_i;
          if (!self_refresh_req_i)
          begin
            s_nxt.st    = S_IDLE;
            s_nxt.p.cke = 4'hf;
            s_nxt.stop  = 1'b0;
          end
        end
        S_ACT:
        begin
          s_nxt.st     = S_RW;
          s_nxt.p.cmd  = s_r.wr ? CMD_WR : CMD_RD;
          s_nxt.p.addr = {1'b0, sp_cur.col[10], 1'b0, sp_cur.col[9:0]};
          s_nxt.p.mask = (bus32_i ? 4'h0 : LANES_16) |
                         (s_r.wr ? ~s_r.be : 4'h0);
          s_nxt.p.doe  = s_r.wr;
          s_nxt.p.dout = s_r.wdata;
          s_nxt.fbcnt  = 2'h0;
          s_nxt.got    = 1'b0;
        end
        S_RW:
        begin
          s_nxt.p.doe  = 1'b0;
          s_nxt.p.mask = 4'hf;
          if (s_r.wr)
          begin
            s_nxt.st             = S_PRE;
            s_nxt.p.cmd          = CMD_PRE;
            s_nxt.p.addr[AP_BIT] = 1'b1;
          end
          else
          begin
            s_nxt.st    = S_WAIT;
            s_nxt.p.cmd = CMD_NOP;
            s_nxt.p.mask = bus32_i ? 4'h0 : LANES_16;
          end
        end
        S_WAIT:
        begin
          if (s_r.got)
          begin
            s_nxt.st             = S_PRE;
            s_nxt.p.cmd          = CMD_PRE;
            s_nxt.p.mask         = 4'hf;
            s_nxt.p.addr[AP_BIT] = 1'b1;
          end
        end
        S_PRE:
        begin
          s_nxt.st  = S_IDLE;
          s_nxt.p   = PINS_IDLE;
          s_nxt.ack = 1'b1;
        end
        S_STAT:
        begin
          s_nxt.st    = S_IDLE;
          s_nxt.p     = PINS_IDLE;
          s_nxt.p.cke = s_r.p.cke;
          s_nxt.ack   = 1'b1;
          if (!s_r.wr)
            s_nxt.rdata = s_r.d2;
        end
      endcase
    end
    if (!rst_n_i)
    begin
      s_nxt    = '0;
      s_nxt.st = S_IDLE;
      s_nxt.p  = PINS_IDLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    s_r <= s_nxt;
  end

  // Pins keep running refreshes while the chip is in reset
  assign pin_src = rst_n_i ? s_r.p : (r_r.ovr ? PINS_REF : PINS_IDLE);

  smi_tap_line #(
    .W   ($bits(smi_pins_type)),
    .RST (PINS_IDLE)
  ) u_cmd_dly (
    .clk_i   (clk_i),
    .rst_n_i (rst_ref_n_i),
    .d_i     (pin_src),
    .sel_i   ({1'b0, cmd_delay_i}),
    .q_o     (pins_q)
  );

  smi_tap_line #(
    .W   (1),
    .RST (1'b0)
  ) u_fb_dly (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (s_r.fb2 && !s_r.fb3),
    .sel_i   (fb_delay_i),
    .q_o     (fb_hit)
  );

  assign ack_o             = s_r.ack;
  assign err_o             = s_r.err;
  assign rdata_o           = s_r.rdata;
  assign self_refresh_o    = (s_r.st == S_SREF);
  assign mem_clk_out_o     = {2{r_r.clk}};
  assign mem_clk_en_o      = pins_q.cke;
  assign dyn_select_n_o    = pins_q.dyn_n;
  assign static_select_n_o = pins_q.stat_n;
  assign {row_strobe_n_o, column_strobe_n_o, mem_write_en_n_o} = pins_q.cmd;
  assign row_col_addr_o    = pins_q.addr;
  assign bank_addr_o       = pins_q.bank;
  assign byte_mask_o       = pins_q.mask;
  assign output_en_n_o     = pins_q.oe_n;
  assign byte_lane_sel_n_o = pins_q.bls_n;
  assign mem_data_o        = pins_q.dout;
  assign mem_data_oe_o     = pins_q.doe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_dyn_win;
    $rose(s_r.st == S_ACT) |-> s_r.p.dyn_n == ~dyn_dec(s_r.addr);
  endproperty
  a_dyn_win: assert property (p_dyn_win) else $error("dyn select");

  property p_stat_win;
    s_r.st == S_STAT |-> s_r.p.stat_n == ~stat_dec(s_r.addr);
  endproperty
  a_stat_win: assert property (p_stat_win) else $error("static sel");

  property p_unmapped;
    s_r.err |-> dyn_dec(s_r.addr) == 4'h0 && stat_dec(s_r.addr) == 4'h0
      && s_r.p.dyn_n == 4'hf && s_r.p.stat_n == 4'hf;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");

  property p_two_bank;
    $rose(s_r.st == S_ACT) && two_banks_i |-> !s_r.p.bank[1];
  endproperty
  a_two_bank: assert property (p_two_bank) else $error("bank1");

  property p_act_cmd;
    $rose(s_r.st == S_ACT) |-> s_r.p.cmd == CMD_ACT
      ##4 s_r.p.cmd == (s_r.wr ? CMD_WR : CMD_RD);
  endproperty
  a_act_cmd: assert property (p_act_cmd) else $error("command");

  property p_mask16;
    s_r.st == S_RW && !bus32_i |-> s_r.p.mask[3:2] == 2'b11;
  endproperty
  a_mask16: assert property (p_mask16) else $error("lane mask");

  property p_sref_cke;
    s_r.st == S_SREF |-> s_r.p.cke == 4'h0;
  endproperty
  a_sref_cke: assert property (p_sref_cke) else $error("cke");

  property p_sref_sw;
    $rose(s_r.st == S_SREF) |-> $past(self_refresh_req_i);
  endproperty
  a_sref_sw: assert property (p_sref_sw) else $error("self ref");

  property p_ref_pend;
    @(posedge clk_i) disable iff (!rst_ref_n_i)
      r_r.cnt == 8'h00 |=> r_r.pend;
  endproperty
  a_ref_pend: assert property (p_ref_pend) else $error("refresh");

  property p_launch;
    $changed(s_r.p) && $past(rst_n_i) |-> r_r.ph == 2'h0;
  endproperty
  a_launch: assert property (p_launch) else $error("launch");

  property p_stat_pol;
    s_r.st == S_STAT && !s_r.wr &&
      (byte_lane_policy_i & ~s_r.p.stat_n) == 4'h0
      |-> s_r.p.bls_n == 4'hf;
  endproperty
  a_stat_pol: assert property (p_stat_pol) else $error("policy");

  c_read:  cover property (s_r.st == S_WAIT ##1 s_r.st == S_PRE);
  c_write: cover property (s_r.st == S_RW && s_r.wr);
  c_sref:  cover property (s_r.st == S_SREF);
  c_stat:  cover property (s_r.st == S_STAT);

endmodule // smi_sdram_if

//--- rtl/smi_tap_line.sv
// Selectable whole-cycle delay line with registered output
`timescale 1ns/1ps
module smi_tap_line
  import smi_pkg::*;
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
)(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  input  wire logic [1:0]   sel_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [2:0][W-1:0] sh;
    logic [W-1:0]      q;
  } smi_tap_type;

  smi_tap_type s_r;
  smi_tap_type s_nxt;

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.sh = {s_r.sh[1:0], d_i};
    s_nxt.q  = (sel_i == 2'h0) ? d_i : s_r.sh[sel_i - 2'h1];
    if (!rst_n_i)
    begin
      s_nxt.sh = {3{RST}};
      s_nxt.q  = RST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    s_r <= s_nxt;
  end

  assign q_o = s_r.q;

endmodule // smi_tap_line
